// [bench/psrs_board.sv]
// Board model: clear, standby, request and wait pins plus port wires
module psrs_board
    import psrs_pkg::*;
(
    // Clock
    input wire logic i_mclk,
    // Port wires
    input wire logic [PSRS_NPORT*PSRS_PORT_W-1:0] i_port_out,
    input wire logic [PSRS_NPORT*PSRS_PORT_W-1:0] i_port_oe,
    output logic [PSRS_NPORT*PSRS_PORT_W-1:0] o_port_in,
    // Clear, standby, request, wait (all active low)
    output logic [3:0] o_pins_n
);
    logic [PSRS_NPORT*PSRS_PORT_W-1:0] float_ff = '0;
    initial o_pins_n = 4'hf;
    // Undriven wires toggle so a stale level never passes for a drive
    always @(posedge i_mclk) float_ff <= ~float_ff;
    assign o_port_in = (i_port_out & i_port_oe) | (float_ff & ~i_port_oe);
    task automatic drive(input logic [3:0] v);
        @(posedge i_mclk);
        o_pins_n <= v;
    endtask : drive
    // Clear leads standby by the setup count when memory is kept
    task automatic standby_pin_n_enter(input bit keep_mem);
        if (keep_mem) begin
            drive(4'h7);
            repeat (PSRS_MEM_SETUP_CLKS) @(posedge i_mclk);
        end
        drive(keep_mem ? 4'h3 : 4'hb);
        drive(4'hb);
    endtask : standby_pin_n_enter
    // Clear goes low about 100 ns before standby is released
    task automatic standby_pin_n_exit();
        drive(4'h3);
        repeat (25) @(posedge i_mclk);
        drive(4'h7);
        repeat (4) @(posedge i_mclk);
        drive(4'hf);
    endtask : standby_pin_n_exit
endmodule : psrs_board

// [bench/psrs_checker.sv]
// Checker: pin state relations for the pin state controller
module psrs_checker
    import psrs_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Register writes
    input wire logic [PSRS_REG_AW-1:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    // Pins
    input wire logic o_acc_done,
    input wire logic o_clk_pin,
    input wire logic o_clk_pin_oe,
    input wire logic [PSRS_ADDR_W-1:0] o_addr,
    input wire logic o_addr_oe,
    input wire logic o_data_oe,
    input wire logic o_addr_strobe_n,
    input wire logic o_read_strobe_n,
    input wire logic o_high_byte_write_n,
    input wire logic o_low_byte_write_n,
    input wire logic o_strobe_oe,
    input wire logic [PSRS_NPORT*PSRS_PORT_W-1:0] o_port,
    input wire logic [PSRS_NPORT*PSRS_PORT_W-1:0] o_port_oe,
    input wire logic [2:0] o_mode
);
    localparam int GNT = PSRS_P6 * PSRS_PORT_W + PSRS_BACK_BIT;
    localparam int RFS = PSRS_P8 * PSRS_PORT_W + PSRS_REFRESH_STROBE_BIT;
    logic bus_release_enable_ff;
    logic refresh_output_enable_ff;
    wire logic in_rst = (o_mode == 3'd1);
    wire logic bus_oe = o_addr_oe | o_data_oe | o_strobe_oe;
    wire logic strb_hi = &{o_addr_strobe_n, o_read_strobe_n,
        o_high_byte_write_n, o_low_byte_write_n};
    // Shadow enables, since the checker cannot read the register
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            bus_release_enable_ff <= PSRS_SYSCTL_RST[PSRS_BIT_BUS_RELEASE_ENABLE];
            refresh_output_enable_ff <= PSRS_SYSCTL_RST[PSRS_BIT_REFRESH_OUTPUT_ENABLE];
        end else if (i_reg_wr && i_reg_addr == PSRS_OFF_SYSCTL) begin
            bus_release_enable_ff <= i_reg_wdata[PSRS_BIT_BUS_RELEASE_ENABLE];
            refresh_output_enable_ff <= i_reg_wdata[PSRS_BIT_REFRESH_OUTPUT_ENABLE];
        end
    end
    // ****************************************
    // Assertions
    // ****************************************
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    a_rst_ports_input: assert property (
        in_rst |-> o_port_oe == '0)
        else $error("port driven during clear");
    a_rst_strobes_idle: assert property (
        in_rst |-> strb_hi && o_strobe_oe && !o_data_oe)
        else $error("strobe or data wrong during clear");
    a_addr_low_early: assert property (
        $rose(in_rst) && !o_acc_done |=> o_addr == '0 && o_addr_oe)
        else $error("address not low half state after clear");
    a_addr_hold_last: assert property (
        $rose(in_rst) && o_acc_done |=> $stable(o_addr) ##1 o_addr == '0)
        else $error("address not held in last state");
    a_hw_all_float: assert property (
        o_mode == 3'h2 |-> !(bus_oe | o_clk_pin_oe | (|o_port_oe)))
        else $error("pin driven in hardware standby");
    a_sw_clock_high: assert property (
        o_mode == 3'h3 |-> o_clk_pin && o_clk_pin_oe && !bus_oe)
        else $error("soft standby pins wrong");
    a_rel_bus_float: assert property (
        o_mode == 3'h4 |-> o_clk_pin_oe && !bus_oe)
        else $error("bus driven while released");
    a_rel_grant_low: assert property (
        o_mode == 3'h4 && bus_release_enable_ff |-> o_port_oe[GNT] && !o_port[GNT])
        else $error("grant not low while released");
    a_rel_refresh_high: assert property (
        o_mode == 3'h4 && refresh_output_enable_ff |-> o_port_oe[RFS] && o_port[RFS])
        else $error("refresh not high while released");
    a_keep_outputs: assert property (
        o_mode == 3'h3 && $past(o_mode) == 3'h3 && !$past(i_reg_wr)
        |-> $stable(o_port_oe[7:0])
        && $stable(o_port[7:0] & o_port_oe[7:0]))
        else $error("retained port changed");
    c_clear: cover property ($rose(in_rst));
    c_hold: cover property ($rose(in_rst) && o_acc_done);
    c_hw: cover property (o_mode == 3'd2);
    c_sw: cover property (o_mode == 3'd3);
    c_rel: cover property (o_mode == 3'd4);
endmodule : psrs_checker

// [bench/tb_top.sv]
// Testbench: clear, standby and bus release sequences
module tb_top
    import psrs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int GNT = PSRS_P6 * PSRS_PORT_W + PSRS_BACK_BIT;
    localparam int RFS = PSRS_P8 * PSRS_PORT_W + PSRS_REFRESH_STROBE_BIT;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    wire logic i_chip_clear_n, i_standby_pin_n, i_bus_request_n, i_wait_n;
    logic [PSRS_REG_AW-1:0] i_reg_addr = '0;
    logic [7:0] i_reg_wdata = 8'h00;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic [7:0] o_reg_rdata;
    logic i_acc_req = 1'b0;
    logic i_acc_write = 1'b0;
    logic i_acc_three_state = 1'b0;
    logic [PSRS_ADDR_W-1:0] i_acc_addr = 24'h5ac3e1;
    logic [PSRS_DATA_W-1:0] i_acc_wdata = 16'h9c36;
    logic o_acc_done, o_clk_pin, o_clk_pin_oe, o_addr_oe, o_data_oe;
    logic [PSRS_ADDR_W-1:0] o_addr;
    logic [PSRS_DATA_W-1:0] o_data;
    logic o_addr_strobe_n, o_read_strobe_n, o_strobe_oe;
    logic o_high_byte_write_n, o_low_byte_write_n;
    wire logic [PSRS_NPORT*PSRS_PORT_W-1:0] i_port;
    logic [PSRS_NPORT*PSRS_PORT_W-1:0] o_port, o_port_oe;
    logic [2:0] o_mode;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    psrs_top dut_u (.*);
    psrs_board board_u (.i_mclk(i_mclk), .i_port_out(o_port),
        .i_port_oe(o_port_oe), .o_port_in(i_port), .o_pins_n({i_chip_clear_n,
        i_standby_pin_n, i_bus_request_n, i_wait_n}));
    // ****************************************
    // Clock, hang guard and shared tasks
    // ****************************************
    always #2 i_mclk = ~i_mclk;
    // Ceiling far above the few hundred cycles the run needs
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            final_report();
        end
    end
    task automatic final_report();
        if (bad_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_mclk);
        i_reg_wr <= 1'b0;
    endtask : reg_wr
    // Read data only stand in the cycle after the strobe
    task automatic reg_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge i_mclk);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_mclk);
        i_reg_rd <= 1'b0;
        #1 check(64'(o_reg_rdata), 64'(exp));
    endtask : reg_chk
    task automatic wait_mode(input logic [2:0] m);
        int n;
        n = 0;
        while (o_mode !== m && n < 60) begin
            @(posedge i_mclk);
            n++;
        end
        #1 check(64'(o_mode), 64'(m));
    endtask : wait_mode
    // Clear lands k cycles into an access; wt holds the wait pin low
    // The pin lags two flops, so it falls two cycles before the clear lands
    task automatic clear_in_access(input bit three, input int k, input bit wt);
        board_u.drive({3'b111, ~wt});
        for (int n = 1; n < 5; n++) begin
            board_u.drive({n <= k, 2'b11, ~wt});
            if (n == 2) begin
                i_acc_req <= 1'b1;
                i_acc_three_state <= three;
                i_acc_write <= !three;
            end
            if (n == 3) i_acc_req <= 1'b0;
        end
        wait_mode(3'd1);
        repeat (3) @(posedge i_mclk);
        #1 check(64'(o_addr), 64'h0);
        check(64'(o_data), 64'h9c36);
        check(o_port_oe, 64'h0);
        check(64'({o_addr_strobe_n, o_read_strobe_n, o_high_byte_write_n,
            o_low_byte_write_n, o_data_oe}), 64'h1e);
        board_u.drive(4'hf);
        wait_mode(3'd0);
    endtask : clear_in_access
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge i_mclk);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_mclk);
        reg_chk(PSRS_OFF_SYSCTL, PSRS_SYSCTL_RST);
        reg_chk(4'h5, 8'h00);
        reg_chk(PSRS_OFF_STATUS, 8'h80);
        for (int k = 0; k < 4; k++) begin
            reg_wr(PSRS_OFF_DIR0, 8'hf0);
            clear_in_access(1'b1, k, 1'b0);
            clear_in_access(1'b0, k, 1'b0);
        end
        clear_in_access(1'b1, 2, 1'b1);
        reg_wr(PSRS_OFF_DIR0, 8'hf0);
        reg_wr(PSRS_OFF_OUT0, 8'ha5);
        reg_wr(PSRS_OFF_DIR0 + 4'h1, 8'hfe);
        reg_chk(PSRS_OFF_DIR0, 8'hf0);
        check(64'({o_port_oe[7:0], o_port[7:0] & 8'hf0}), 64'hf0a0);
        check(64'(o_port_oe[23:16]), 64'hfe);
        reg_wr(PSRS_OFF_SYSCTL, 8'h09);
        wait_mode(3'd3);
        repeat (4) @(posedge i_mclk);
        #1 check(64'({o_clk_pin, o_addr_oe, o_port_oe[7:0]}),
            64'h2f0);
        reg_wr(PSRS_OFF_SYSCTL, 8'h07);
        wait_mode(3'd0);
        board_u.drive(4'hd);
        wait_mode(3'd4);
        #1 check(64'({o_port_oe[GNT], o_port[GNT], o_port[RFS], o_addr_oe}),
            64'ha);
        reg_chk(PSRS_OFF_STATUS, 8'h8c);
        board_u.drive(4'hf);
        wait_mode(3'd0);
        reg_wr(PSRS_OFF_SYSCTL, 8'h01);
        board_u.standby_pin_n_enter(1'b1);
        wait_mode(3'd2);
        check(64'({o_clk_pin_oe, o_addr_oe, o_data_oe}), 64'h0);
        check(o_port_oe, 64'h0);
        board_u.standby_pin_n_exit();
        wait_mode(3'd0);
        reg_wr(PSRS_OFF_SYSCTL, 8'h00);
        board_u.standby_pin_n_enter(1'b0);
        wait_mode(3'd2);
        board_u.standby_pin_n_exit();
        wait_mode(3'd0);
        final_report();
    end
endmodule : tb_top

bind psrs_top psrs_checker chk_u (.*);

// [hdl/psrs_bus.sv]
// External access state sequencer with address and strobe outputs
module psrs_bus
    import psrs_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Access request
    input wire logic i_req,
    input wire logic i_write,
    input wire logic i_three_state,
    input wire logic [PSRS_ADDR_W-1:0] i_addr,
    input wire logic [PSRS_DATA_W-1:0] i_wdata,
    input wire logic i_wait,
    input wire logic i_clear,
    // Bus pins (before mode override)
    output logic [PSRS_ADDR_W-1:0] o_addr,
    output logic o_as_n,
    output logic o_rd_n,
    output logic o_wr_n,
    output logic o_data_oe,
    output logic [PSRS_DATA_W-1:0] o_data,
    output psrs_bstate_t o_bstate,
    output logic o_done
);

    psrs_bstate_t st_ff, nxt_st;
    logic [PSRS_ADDR_W-1:0] addr_ff;
    logic [PSRS_DATA_W-1:0] data_ff;
    logic wr_ff;
    logic three_ff;
    wire last_state;

    // Final state: third, or second of a two-state access
    assign last_state = (st_ff == PSRS_BS_THIRD) ||
        (st_ff == PSRS_BS_SECOND && !three_ff && !i_wait);

    // Wait inserts a repeat of the second state
    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff)
            PSRS_BS_IDLE: if (i_req) nxt_st = PSRS_BS_FIRST;
            PSRS_BS_FIRST: nxt_st = PSRS_BS_SECOND;
            PSRS_BS_SECOND: begin
                if (i_wait) nxt_st = PSRS_BS_SECOND;
                else if (three_ff) nxt_st = PSRS_BS_THIRD;
                else nxt_st = PSRS_BS_IDLE;
            end
            PSRS_BS_THIRD: nxt_st = PSRS_BS_IDLE;
        endcase
        if (i_clear) nxt_st = PSRS_BS_IDLE;
    end

    // Access latches; address kept after the access ends
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            st_ff <= PSRS_BS_IDLE;
            addr_ff <= '0;
            data_ff <= '0;
            wr_ff <= 1'b0;
            three_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            if (st_ff == PSRS_BS_IDLE && i_req && !i_clear) begin
                addr_ff <= i_addr;
                data_ff <= i_wdata;
                wr_ff <= i_write;
                three_ff <= i_three_state;
            end
        end
    end

    wire active = (st_ff != PSRS_BS_IDLE);
    assign o_addr = addr_ff;
    assign o_data = data_ff;
    assign o_as_n = !active;
    assign o_rd_n = !(active && !wr_ff);
    assign o_wr_n = !(active && wr_ff && st_ff != PSRS_BS_FIRST);
    assign o_data_oe = active && wr_ff;
    assign o_bstate = st_ff;
    assign o_done = active && last_state;

endmodule : psrs_bus

// [hdl/psrs_pkg.sv]
// Package: constants and types for the pin state controller
package psrs_pkg;

    // ******************************************************
    // Widths
    // ******************************************************
    localparam int PSRS_ADDR_W = 24;
    localparam int PSRS_DATA_W = 16;
    localparam int PSRS_PORT_W = 8;
    localparam int PSRS_NPORT = 8;
    localparam int PSRS_REG_AW = 4;

    // ******************************************************
    // Register offsets (word index on the plain port)
    // ******************************************************
    localparam logic [3:0] PSRS_OFF_SYSCTL = 4'h0;
    localparam logic [3:0] PSRS_OFF_STATUS = 4'h1;
    localparam logic [3:0] PSRS_OFF_DIR0 = 4'h8;
    localparam logic [3:0] PSRS_OFF_OUT0 = 4'hc;

    // ******************************************************
    // Control register bit positions
    // ******************************************************
    localparam int PSRS_BIT_MEMEN = 0;
    localparam int PSRS_BIT_BUS_RELEASE_ENABLE = 1;
    localparam int PSRS_BIT_REFRESH_OUTPUT_ENABLE = 2;
    localparam int PSRS_BIT_SWSTBY = 3;
    localparam logic [7:0] PSRS_SYSCTL_RST = 8'h01;

    // ******************************************************
    // Port indices (port 6 and 8 carry special pins)
    // ******************************************************
    localparam int PSRS_P6 = 2;
    localparam int PSRS_P8 = 4;
    localparam int PSRS_WAIT_BIT = 0;
    localparam int PSRS_BUS_REQUEST_N_BIT = 1;
    localparam int PSRS_BACK_BIT = 2;
    localparam int PSRS_REFRESH_STROBE_BIT = 0;

    // ******************************************************
    // Timing
    // ******************************************************
    localparam int PSRS_CLK_PS = 4000;
    localparam int PSRS_MEM_SETUP_CLKS = 10;

    // Operating mode of the pins
    typedef enum logic [2:0] {
        PSRS_MODE_RUN = 3'b000,
        PSRS_MODE_RESET = 3'b001,
        PSRS_MODE_HWSTBY = 3'b010,
        PSRS_MODE_SWSTBY = 3'b011,
        PSRS_MODE_BUSREL = 3'b100
    } psrs_mode_t;

    // External access bus state
    typedef enum logic [1:0] {
        PSRS_BS_IDLE = 2'b00,
        PSRS_BS_FIRST = 2'b01,
        PSRS_BS_SECOND = 2'b10,
        PSRS_BS_THIRD = 2'b11
    } psrs_bstate_t;

endpackage : psrs_pkg

// [hdl/psrs_sync.sv]
// Two-stage synchroniser for asynchronous pin levels
module psrs_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Data
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    // First stage feeds only the second
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            meta_ff <= RST_VAL;
            q_ff <= RST_VAL;
        end else begin
            meta_ff <= i_d;
            q_ff <= meta_ff;
        end
    end

    assign o_q = q_ff;

endmodule : psrs_sync

// [hdl/psrs_top.sv]
// Pin state controller: reset, standby and bus-release pin control
//
// Our own choices: the plain strobed port and the placing of the registers.
module psrs_top
    import psrs_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Board pins (asynchronous)
    input wire logic i_chip_clear_n,
    input wire logic i_standby_pin_n,
    input wire logic i_bus_request_n,
    input wire logic i_wait_n,
    // Register port
    input wire logic [PSRS_REG_AW-1:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    // Access request from the core
    input wire logic i_acc_req,
    input wire logic i_acc_write,
    input wire logic i_acc_three_state,
    input wire logic [PSRS_ADDR_W-1:0] i_acc_addr,
    input wire logic [PSRS_DATA_W-1:0] i_acc_wdata,
    output logic o_acc_done,
    // Clock pin
    output logic o_clk_pin,
    output logic o_clk_pin_oe,
    // Address and data bus pins
    output logic [PSRS_ADDR_W-1:0] o_addr,
    output logic o_addr_oe,
    output logic [PSRS_DATA_W-1:0] o_data,
    output logic o_data_oe,
    // Strobes
    output logic o_addr_strobe_n,
    output logic o_read_strobe_n,
    output logic o_high_byte_write_n,
    output logic o_low_byte_write_n,
    output logic o_strobe_oe,
    // General ports
    input wire logic [PSRS_NPORT*PSRS_PORT_W-1:0] i_port,
    output logic [PSRS_NPORT*PSRS_PORT_W-1:0] o_port,
    output logic [PSRS_NPORT*PSRS_PORT_W-1:0] o_port_oe,
    // Status
    output logic [2:0] o_mode
);

    // ******************************************************
    // Pin synchronisers
    // ******************************************************
    logic clr_sync;
    logic standby_pin_n_sync;
    logic bus_request_n_sync;
    logic wait_sync;
    logic [PSRS_NPORT*PSRS_PORT_W-1:0] port_sync;

    psrs_sync #(.W(4), .RST_VAL(4'hf)) u_sync_pins (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_d({i_chip_clear_n, i_standby_pin_n, i_bus_request_n, i_wait_n}),
        .o_q({clr_sync, standby_pin_n_sync, bus_request_n_sync, wait_sync})
    );

    psrs_sync #(.W(PSRS_NPORT*PSRS_PORT_W)) u_sync_port (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_d(i_port),
        .o_q(port_sync)
    );

    // ******************************************************
    // Reset sampling on the falling edge
    // ******************************************************
    // Falling-edge sample keeps the half-state address timing
    logic clr_fall_ff;
    always_ff @(negedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            clr_fall_ff <= 1'b0;
        end else begin
            clr_fall_ff <= !clr_sync;
        end
    end

    // Clear path from the synchronised pin level or the falling-edge sample
    wire clear_now = !clr_sync || clr_fall_ff;

    // ******************************************************
    // Registers
    // ******************************************************
    logic [7:0] sysctl_ff;
    logic [PSRS_PORT_W-1:0] dir_ff [PSRS_NPORT];
    logic [PSRS_PORT_W-1:0] out_ff [PSRS_NPORT];
    logic [7:0] rdata_ff;
    // Pin mode is read by the register logic, so declared early
    psrs_mode_t mode;

    wire memen = sysctl_ff[PSRS_BIT_MEMEN];
    wire bus_release_enable = sysctl_ff[PSRS_BIT_BUS_RELEASE_ENABLE];
    wire refresh_output_enable = sysctl_ff[PSRS_BIT_REFRESH_OUTPUT_ENABLE];
    wire swstby = sysctl_ff[PSRS_BIT_SWSTBY];

    // Register index decode helper; neither read nor write uses it
    function automatic logic is_port(input logic [3:0] a,
                                     input logic [3:0] base,
                                     output int idx);
        idx = int'(a - base);
        return (a >= base) && (a < base + 4'(4));
    endfunction : is_port

    // Port registers and control; chip clear returns all to input
    genvar g;
    generate
        for (g = 0; g < PSRS_NPORT; g++) begin : g_port
            always_ff @(posedge i_mclk or posedge i_rst) begin
                if (i_rst) begin
                    dir_ff[g] <= '0;
                    out_ff[g] <= '0;
                end else if (clear_now) begin
                    dir_ff[g] <= '0;
                end else if (i_reg_wr &&
                             i_reg_addr == PSRS_OFF_DIR0 + 4'(g / 2) &&
                             g % 2 == 0) begin
                    dir_ff[g] <= i_reg_wdata;
                end else if (i_reg_wr &&
                             i_reg_addr == PSRS_OFF_OUT0 + 4'(g / 2) &&
                             g % 2 == 0) begin
                    out_ff[g] <= i_reg_wdata;
                end
            end
        end
    endgenerate

    // Control register write
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            sysctl_ff <= PSRS_SYSCTL_RST;
        end else if (i_reg_wr && i_reg_addr == PSRS_OFF_SYSCTL) begin
            // Standby bit leaves only by a write; no wake source here
            sysctl_ff <= i_reg_wdata;
        end
    end

    // ******************************************************
    // Mode selection
    // ******************************************************
    // Bus release needs both the enable and a pending request
    wire bus_rel = bus_release_enable && !bus_request_n_sync;

    // Standby pin has top priority, then chip clear
    assign mode = !standby_pin_n_sync ? PSRS_MODE_HWSTBY :
        clear_now ? PSRS_MODE_RESET :
        swstby ? PSRS_MODE_SWSTBY :
        bus_rel ? PSRS_MODE_BUSREL : PSRS_MODE_RUN;
    assign o_mode = mode;

    // ******************************************************
    // Bus sequencer
    // ******************************************************
    logic [PSRS_ADDR_W-1:0] seq_addr;
    logic [PSRS_DATA_W-1:0] seq_data;
    logic seq_as_n, seq_rd_n, seq_wr_n, seq_doe;

    psrs_bus u_bus (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_req(i_acc_req && mode == PSRS_MODE_RUN),
        .i_write(i_acc_write),
        .i_three_state(i_acc_three_state),
        .i_addr(i_acc_addr),
        .i_wdata(i_acc_wdata),
        .i_wait(!wait_sync),
        .i_clear(mode != PSRS_MODE_RUN),
        .o_addr(seq_addr),
        .o_as_n(seq_as_n),
        .o_rd_n(seq_rd_n),
        .o_wr_n(seq_wr_n),
        .o_data_oe(seq_doe),
        .o_data(seq_data),
        .o_bstate(),
        .o_done(o_acc_done)
    );

    // ******************************************************
    // Address behaviour under chip clear
    // ******************************************************
    // Hold marks a clear that hit in the final state of an access
    logic hold_ff;
    logic addr_low_ff;
    // Latched access length, not the live request pins, decides
    wire seq_last = o_acc_done;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            hold_ff <= 1'b0;
            addr_low_ff <= 1'b1;
        end else if (clear_now) begin
            hold_ff <= seq_last && !hold_ff && !addr_low_ff;
            addr_low_ff <= clr_fall_ff &&
                !(seq_last && !hold_ff);
        end else begin
            hold_ff <= 1'b0;
            addr_low_ff <= 1'b0;
        end
    end

    // ******************************************************
    // Pin drive
    // ******************************************************
    wire run = (mode == PSRS_MODE_RUN);
    wire in_reset = (mode == PSRS_MODE_RESET);
    wire retain = (mode == PSRS_MODE_SWSTBY) || (mode == PSRS_MODE_BUSREL);

    assign o_clk_pin = (mode == PSRS_MODE_SWSTBY) ? 1'b1 : i_mclk;
    assign o_clk_pin_oe = (mode != PSRS_MODE_HWSTBY);

    // Address driven low or held under clear, floats in standby
    assign o_addr = (in_reset && addr_low_ff) ? '0 : seq_addr;
    assign o_addr_oe = run || in_reset;
    assign o_data = seq_data;
    assign o_data_oe = run && seq_doe;

    // Strobes inactive high during clear, float otherwise off-run
    assign o_addr_strobe_n = run ? seq_as_n : 1'b1;
    assign o_read_strobe_n = run ? seq_rd_n : 1'b1;
    assign o_high_byte_write_n = run ? seq_wr_n : 1'b1;
    assign o_low_byte_write_n = run ? seq_wr_n : 1'b1;
    assign o_strobe_oe = run || in_reset;

    // Port pins: retention floats inputs and holds outputs
    generate
        for (g = 0; g < PSRS_NPORT; g++) begin : g_pin
            wire [PSRS_PORT_W-1:0] dir_eff;
            wire [PSRS_PORT_W-1:0] val;
            logic [PSRS_PORT_W-1:0] oe;
            logic [PSRS_PORT_W-1:0] v;
            assign dir_eff = (g == PSRS_P6) ?
                (dir_ff[g] & ~(PSRS_PORT_W'(1) << PSRS_WAIT_BIT)) :
                dir_ff[g];
            assign val = out_ff[g];
            always_comb begin
                oe = (run || retain) ? dir_eff : '0;
                v = val;
                if (g == PSRS_P6 && mode == PSRS_MODE_BUSREL) begin
                    oe[PSRS_BACK_BIT] = 1'b1;
                    v[PSRS_BACK_BIT] = 1'b0;
                    oe[PSRS_BUS_REQUEST_N_BIT] = 1'b0;
                end
                if (g == PSRS_P8 && mode == PSRS_MODE_BUSREL && refresh_output_enable) begin
                    oe[PSRS_REFRESH_STROBE_BIT] = 1'b1;
                    v[PSRS_REFRESH_STROBE_BIT] = 1'b1;
                end
            end
            assign o_port[g*PSRS_PORT_W +: PSRS_PORT_W] = v;
            assign o_port_oe[g*PSRS_PORT_W +: PSRS_PORT_W] = oe;
        end
    endgenerate

    // ******************************************************
    // Register read
    // ******************************************************
    wire [7:0] status = {memen, 2'b00, !standby_pin_n_sync, !bus_request_n_sync, mode};
    logic [7:0] rsel;
    always_comb begin
        rsel = 8'h00;
        if (i_reg_addr == PSRS_OFF_SYSCTL) rsel = sysctl_ff;
        else if (i_reg_addr == PSRS_OFF_STATUS) rsel = status;
        else if (i_reg_addr >= PSRS_OFF_DIR0 && i_reg_addr < PSRS_OFF_OUT0)
            rsel = dir_ff[2 * (i_reg_addr - PSRS_OFF_DIR0)];
        else if (i_reg_addr >= PSRS_OFF_OUT0)
            rsel = port_sync[8*(2*(i_reg_addr - PSRS_OFF_OUT0)) +: 8];
    end

    // Read data stands one cycle after the strobe only
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= i_reg_rd ? rsel : 8'h00;
        end
    end
    assign o_reg_rdata = rdata_ff;

endmodule : psrs_top
